/* hw/asfr_regs.sv */
// angle, device condition and fault latch register bank with read port and clear controls

`include "asfr_map.svh"

module asfr_regs (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// register read port from the serial front end
	input wire logic rd_strobe,
	input wire logic [7:0] rd_addr,
	output logic [15:0] rd_data_ff,
	output logic rd_valid_ff,
	output logic rd_unmapped_ff,
	// command register controls, one-cycle pulses
	input wire logic fault_clear,
	input wire logic wipe_done_flags,
	// sensing inputs
	input wire logic [11:0] angle_code,
	input wire logic caution_any,
	input wire logic [11:0] flag_mask_bits,
	input wire asfr_pkg::asfr_fault_ev_s fault_ev,
	input wire asfr_pkg::asfr_cond_in_s cond_in,
	input wire asfr_pkg::asfr_done_ev_s done_ev,
	// summary flag for pins outside the bank
	output logic summary_fault_flag_ff
);

	// state
	asfr_pkg::asfr_fault_t fault_ff;
	asfr_pkg::asfr_fault_t nxt_fault;
	asfr_pkg::asfr_fault_t read_mask_ff;
	asfr_pkg::asfr_fault_t nxt_read_mask;
	asfr_pkg::asfr_fault_t fault_set;
	logic special_done_flag_ff;
	logic nxt_special_done_flag;
	logic boot_done_flag_ff;
	logic nxt_boot_done_flag;
	logic startup_seen_ff;
	logic nxt_startup_seen;
	asfr_pkg::asfr_word_t nxt_rd_data;
	logic nxt_rd_valid;
	logic nxt_rd_unmapped;
	logic nxt_summary;

	// combinational views of the three words
	logic summary_fault_flag;
	logic undervoltage_live_flag;
	logic angle_valid_flag;
	asfr_pkg::asfr_word_t pos_word;
	asfr_pkg::asfr_word_t cond_word;
	asfr_pkg::asfr_word_t fault_word;

	// fault event vector; bit 11 honours its own mask, the rest are raw events
	always_comb
	begin
		fault_set = fault_ev;
		fault_set[`ASFR_FLT_CAUTION_BIT] = caution_any & ~flag_mask_bits[`ASFR_FLT_CAUTION_BIT];
	end

	// summary and live undervoltage, both steered by the nvm mask except caution_any, which sets the summary unmasked
	always_comb
	begin
		summary_fault_flag = (|(fault_ff & ~flag_mask_bits)) | caution_any;
		undervoltage_live_flag = (fault_ev.supply_uv & ~flag_mask_bits[`ASFR_FLT_SUPPLY_UV_BIT])
			| (fault_ev.regulator_uv & ~flag_mask_bits[`ASFR_FLT_REG_UV_BIT]);
		angle_valid_flag = cond_in.pll_locked & startup_seen_ff & ~cond_in.boot_running;
	end

	// position reading word: zero, summary, uv, parity, angle
	always_comb
	begin
		pos_word = `ASFR_WORD_RESET;
		pos_word[`ASFR_POS_ZERO_BIT] = 1'b0;
		pos_word[`ASFR_POS_SUMMARY_BIT] = summary_fault_flag;
		pos_word[`ASFR_POS_UV_BIT] = undervoltage_live_flag;
		pos_word[11:0] = angle_code;
		// inverted xor so the whole word holds an odd count of ones
		pos_word[`ASFR_POS_PARITY_BIT] = ~(^{summary_fault_flag, undervoltage_live_flag, angle_code});
	end

	// condition word; unused bits read zero
	always_comb
	begin
		cond_word = `ASFR_WORD_RESET;
		cond_word[15:12] = `ASFR_COND_TAG;
		cond_word[9:8] = cond_in.chip_index;
		cond_word[7] = cond_in.spin_direction;
		cond_word[5] = special_done_flag_ff;
		cond_word[4] = boot_done_flag_ff;
		cond_word[3] = cond_in.logic_selftest_running;
		cond_word[2] = cond_in.hall_selftest_running;
		cond_word[1] = cond_in.boot_running;
		cond_word[0] = angle_valid_flag;
	end

	// fault word
	always_comb
	begin
		fault_word = {`ASFR_FAULT_TAG, fault_ff};
	end

	// fault latch next state; a new event wins over a clear in the same cycle
	always_comb
	begin
		nxt_fault = fault_ff;
		nxt_read_mask = read_mask_ff;
		if (fault_clear)
		begin
			// only bits the host has actually seen go away, so an unseen fault survives
			nxt_fault = fault_ff & ~read_mask_ff;
			nxt_read_mask = `ASFR_FLT_ZERO;
		end
		if (rd_strobe && rd_addr == `ASFR_FAULT_OFFSET)
		begin
			nxt_read_mask = fault_ff;
		end
		// persistent undervoltage keeps re-setting bit 3 through the clear
		nxt_fault = nxt_fault | fault_set;
	end

	// done flags: set beats clear, completion beats trigger
	always_comb
	begin
		nxt_special_done_flag = special_done_flag_ff;
		if (done_ev.special_trigger || wipe_done_flags)
		begin
			nxt_special_done_flag = 1'b0;
		end
		if (done_ev.special_complete)
		begin
			nxt_special_done_flag = 1'b1;
		end
		nxt_boot_done_flag = boot_done_flag_ff;
		if (wipe_done_flags)
		begin
			nxt_boot_done_flag = 1'b0;
		end
		if (done_ev.boot_complete)
		begin
			nxt_boot_done_flag = 1'b1;
		end
		// startup memory is not host-clearable, unlike the boot done flag
		nxt_startup_seen = startup_seen_ff | done_ev.boot_complete;
	end

	// read port: answer one cycle after the strobe
	always_comb
	begin
		nxt_rd_data = rd_data_ff;
		nxt_rd_valid = rd_strobe;
		nxt_rd_unmapped = 1'b0;
		nxt_summary = summary_fault_flag;
		if (rd_strobe)
		begin
			unique case (rd_addr)
				`ASFR_POS_OFFSET: nxt_rd_data = pos_word;
				`ASFR_COND_OFFSET: nxt_rd_data = cond_word;
				`ASFR_FAULT_OFFSET: nxt_rd_data = fault_word;
				default:
				begin
					nxt_rd_data = `ASFR_WORD_RESET;
					nxt_rd_unmapped = 1'b1;
				end
			endcase
		end
	end

	// fault latch registers; reset flag comes up set
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fault_ff <= `ASFR_FAULT_RESET;
			read_mask_ff <= `ASFR_FLT_ZERO;
		end
		else
		begin
			fault_ff <= nxt_fault;
			read_mask_ff <= nxt_read_mask;
		end
	end

	// condition flag registers
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			special_done_flag_ff <= 1'b0;
			boot_done_flag_ff <= 1'b0;
			startup_seen_ff <= 1'b0;
		end
		else
		begin
			special_done_flag_ff <= nxt_special_done_flag;
			boot_done_flag_ff <= nxt_boot_done_flag;
			startup_seen_ff <= nxt_startup_seen;
		end
	end

	// read port and summary output registers
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data_ff <= `ASFR_WORD_RESET;
			rd_valid_ff <= 1'b0;
			rd_unmapped_ff <= 1'b0;
			summary_fault_flag_ff <= 1'b0;
		end
		else
		begin
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			rd_unmapped_ff <= nxt_rd_unmapped;
			summary_fault_flag_ff <= nxt_summary;
		end
	end

	// checks on the driven outputs and latches
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_pos_read;
		rd_strobe && rd_addr == `ASFR_POS_OFFSET;
	endsequence

	sequence s_cond_read;
		rd_strobe && rd_addr == `ASFR_COND_OFFSET;
	endsequence

	sequence s_fault_read;
		rd_strobe && rd_addr == `ASFR_FAULT_OFFSET;
	endsequence

	// any strobe that hits none of the three words
	sequence s_unmapped_read;
		rd_strobe && rd_addr != `ASFR_POS_OFFSET && rd_addr != `ASFR_COND_OFFSET
			&& rd_addr != `ASFR_FAULT_OFFSET;
	endsequence

	// position word and summary pin
	AST_POS_SUMMARY: assert property (s_pos_read |=> rd_valid_ff
		&& rd_data_ff[`ASFR_POS_SUMMARY_BIT] == $past(summary_fault_flag) && !rd_data_ff[`ASFR_POS_ZERO_BIT])
		else $error("summary flag or top bit wrong in position word");
	AST_SUMMARY_PIN: assert property (1'b1 |=> summary_fault_flag_ff == $past(summary_fault_flag))
		else $error("summary flag output lags more than one cycle");
	AST_POS_UV: assert property (s_pos_read ##0 (fault_ev.supply_uv && !flag_mask_bits[3])
		|=> rd_data_ff[`ASFR_POS_UV_BIT])
		else $error("unmasked supply undervoltage not shown");
	AST_POS_PARITY: assert property (s_pos_read |=> ^rd_data_ff)
		else $error("position word parity is not odd");
	AST_POS_ANGLE: assert property (s_pos_read |=> rd_data_ff[11:0] == $past(angle_code))
		else $error("angle field does not match input");
	// condition word and unmapped reads
	AST_TAGS: assert property (s_cond_read |=> rd_data_ff[15:12] == `ASFR_COND_TAG)
		else $error("condition tag wrong");
	AST_COND_DONE: assert property (s_cond_read
		|=> rd_data_ff[5:4] == $past({special_done_flag_ff, boot_done_flag_ff}))
		else $error("done flags not shown in condition word");
	AST_ANGLE_VALID: assert property (s_cond_read ##0 (cond_in.boot_running || !cond_in.pll_locked)
		|=> !rd_data_ff[0])
		else $error("angle valid shown while booting or unlocked");
	AST_BOOT_RUN: assert property (s_cond_read ##0 cond_in.boot_running |=> rd_data_ff[1])
		else $error("boot running not shown");
	AST_UNMAPPED: assert property (s_unmapped_read |=> rd_unmapped_ff && rd_data_ff == `ASFR_WORD_RESET)
		else $error("unmapped read not flagged or not zero");
	// fault latch
	AST_FAULT_TAG: assert property (s_fault_read
		|=> rd_data_ff[15:12] == `ASFR_FAULT_TAG && rd_data_ff[11:0] == $past(fault_ff))
		else $error("fault word wrong");
	AST_STICKY: assert property (!fault_clear |=> (($past(fault_ff) & ~fault_ff) == `ASFR_FLT_ZERO))
		else $error("fault flag dropped without clear");
	AST_UNREAD_KEPT: assert property (fault_clear
		|=> (($past(fault_ff) & ~$past(read_mask_ff) & ~fault_ff) == `ASFR_FLT_ZERO))
		else $error("unread fault flag was cleared");
	AST_UV_RESET: assert property ((fault_clear && fault_ev.supply_uv)
		|=> fault_ff[`ASFR_FLT_SUPPLY_UV_BIT])
		else $error("supply undervoltage flag not re-set");
	AST_CAUTION: assert property ((caution_any && !flag_mask_bits[11]) |=> fault_ff[`ASFR_FLT_CAUTION_BIT])
		else $error("unmasked caution did not latch");
	// done flags
	AST_SPECIAL_DONE: assert property ((done_ev.special_trigger && !done_ev.special_complete)
		|=> !special_done_flag_ff)
		else $error("special done not cleared by trigger");
	AST_SPECIAL_SET: assert property (done_ev.special_complete |=> special_done_flag_ff)
		else $error("special done not set on completion");
	AST_SET_WINS: assert property ((wipe_done_flags && done_ev.boot_complete) |=> boot_done_flag_ff)
		else $error("boot done lost to simultaneous clear");
	AST_WIPE: assert property ((wipe_done_flags && !done_ev.boot_complete && !done_ev.special_complete)
		|=> !boot_done_flag_ff && !special_done_flag_ff)
		else $error("clear-done did not wipe flags");

endmodule // asfr_regs

/* hw/asfr_map.svh */
// register offsets, tags, field positions and reset values of the angle/status/fault registers
`ifndef ASFR_MAP_SVH
`define ASFR_MAP_SVH

// byte offsets of the three read-only words
`define ASFR_POS_OFFSET 8'h20
`define ASFR_COND_OFFSET 8'h22
`define ASFR_FAULT_OFFSET 8'h24

// hard-coded tags in bits 15:12
`define ASFR_COND_TAG 4'h8
`define ASFR_FAULT_TAG 4'hA

// position reading field positions
`define ASFR_POS_ZERO_BIT 15
`define ASFR_POS_SUMMARY_BIT 14
`define ASFR_POS_UV_BIT 13
`define ASFR_POS_PARITY_BIT 12

// fault latch field positions
`define ASFR_FLT_CAUTION_BIT 11
`define ASFR_FLT_SUPPLY_UV_BIT 3
`define ASFR_FLT_REG_UV_BIT 2
`define ASFR_FLT_RESET_BIT 0

// reset values: only the reset flag comes up set
`define ASFR_FAULT_RESET 12'h001
`define ASFR_WORD_RESET 16'h0000
`define ASFR_FLT_ZERO 12'h000

`endif

/* hw/asfr_pkg.sv */
// types shared by the angle/status/fault register bank
package asfr_pkg;

	typedef logic [15:0] asfr_word_t;
	typedef logic [11:0] asfr_fault_t;

	// one-cycle event pulses (levels for undervoltage), bit 11 down to bit 0; all but bit 11 feed the fault latch
	typedef struct packed {
		logic caution;
		logic selftest_fail;
		logic averaging;
		logic quadrature;
		logic lock_loss;
		logic zero_cross;
		logic eeprom_multibit;
		logic osc_watchdog;
		logic supply_uv;
		logic regulator_uv;
		logic mag_low;
		logic reset_evt;
	} asfr_fault_ev_s;

	// live condition inputs
	typedef struct packed {
		logic [1:0] chip_index;
		logic spin_direction;
		logic logic_selftest_running;
		logic hall_selftest_running;
		logic boot_running;
		logic pll_locked;
	} asfr_cond_in_s;

	// event pulses steering the done flags
	typedef struct packed {
		logic special_trigger;
		logic special_complete;
		logic boot_complete;
	} asfr_done_ev_s;

endpackage : asfr_pkg

/* test/asfr_host.sv */
// host model issuing register reads and clear pulses toward the bank
module asfr_host (
	// clock
	input wire logic sys_clk,
	// read port
	output logic rd_strobe,
	output logic [7:0] rd_addr,
	input wire logic [15:0] rd_data_ff,
	input wire logic rd_valid_ff,
	input wire logic rd_unmapped_ff,
	// clear controls
	output logic fault_clear,
	output logic wipe_done_flags
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle levels at time zero
	initial
	begin
		rd_strobe = 1'b0;
		rd_addr = 8'h00;
		fault_clear = 1'b0;
		wipe_done_flags = 1'b0;
	end

	// one word per read; address inverted while idle so a stale value cannot pass
	task automatic read_reg(input logic [7:0] addr, input int idle, output logic [15:0] data, output logic vld,
		output logic unm);
		repeat (idle) @(posedge sys_clk);
		@(posedge sys_clk);
		rd_strobe <= 1'b1;
		rd_addr <= addr;
		@(posedge sys_clk);
		rd_strobe <= 1'b0;
		rd_addr <= ~addr;
		#1;
		data = rd_data_ff;
		vld = rd_valid_ff;
		unm = rd_unmapped_ff;
	endtask

	// clear pulse: one cycle of fault clear and/or done-flag wipe, whether or not the flags were read
	task automatic pulse(input logic fc, input logic wd);
		@(posedge sys_clk);
		fault_clear <= fc;
		wipe_done_flags <= wd;
		@(posedge sys_clk);
		fault_clear <= 1'b0;
		wipe_done_flags <= 1'b0;
	endtask
endmodule // asfr_host

/* test/asfr_regs_tb_top.sv */
// self-checking bench for the angle/status/fault register bank
`include "asfr_map.svh"
module asfr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic caution_any = 1'b0;
	logic rd_strobe, rd_valid_ff, rd_unmapped_ff, fault_clear, wipe_done_flags, summary_fault_flag_ff, vld, unm;
	logic [7:0] rd_addr;
	logic [15:0] rd_data_ff, data;
	logic [11:0] angle_code = 12'h000;
	logic [11:0] flag_mask_bits = 12'h000;
	asfr_pkg::asfr_fault_ev_s fault_ev = '0;
	asfr_pkg::asfr_cond_in_s cond_in = '0;
	asfr_pkg::asfr_done_ev_s done_ev = '0;
	asfr_pkg::asfr_fault_t exp_fault;
	logic [15:0] exp_w;
	int num_errors = 0;
	int samples_checked = 0;
	int seed = 32'heb76;
	int i;

	always #5 sys_clk = ~sys_clk;

	asfr_regs i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
		.rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .rd_unmapped_ff(rd_unmapped_ff),
		.fault_clear(fault_clear), .wipe_done_flags(wipe_done_flags), .angle_code(angle_code),
		.caution_any(caution_any), .flag_mask_bits(flag_mask_bits), .fault_ev(fault_ev), .cond_in(cond_in),
		.done_ev(done_ev), .summary_fault_flag_ff(summary_fault_flag_ff));
	asfr_host i_host (.sys_clk(sys_clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data_ff(rd_data_ff),
		.rd_valid_ff(rd_valid_ff), .rd_unmapped_ff(rd_unmapped_ff), .fault_clear(fault_clear),
		.wipe_done_flags(wipe_done_flags));

	// expected position word: zero, summary, live undervoltage, odd parity, angle
	function automatic logic [15:0] pos_word(logic [11:0] position_reading, logic [11:0] msk, logic cau, logic [1:0] uvl);
		logic s;
		logic u;
		s = |(exp_fault & ~msk) | cau;
		u = |(uvl & ~msk[3:2]);
		return {1'b0, s, u, ~^{s, u, position_reading}, position_reading};
	endfunction

	// expected condition word; angle valid needs lock, boot seen and boot not running
	function automatic logic [15:0] cond_word(asfr_pkg::asfr_cond_in_s c, logic sd, logic bd, logic booted);
		return {`ASFR_COND_TAG, 2'b00, c.chip_index, c.spin_direction, 1'b0, sd, bd, c.logic_selftest_running,
			c.hall_selftest_running, c.boot_running, c.pll_locked & booted & ~c.boot_running};
	endfunction

	task automatic chk(logic [15:0] exp, logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask

	task automatic step(int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// random idle gap of zero or one extra cycle before each read; strobes always have an idle cycle between them
	task automatic rd_chk(logic [7:0] a, logic [15:0] exp);
		i_host.read_reg(a, $random(seed) & 32'h1, data, vld, unm);
		chk(16'h0001, {15'h0000, vld});
		chk(exp, data);
	endtask

	task automatic flt_chk;
		rd_chk(`ASFR_FAULT_OFFSET, {`ASFR_FAULT_TAG, exp_fault});
	endtask

	// one-cycle event pulses, then let the latches settle
	task automatic fire(logic [11:0] ev, logic [2:0] dn);
		@(posedge sys_clk);
		fault_ev <= ev;
		done_ev <= dn;
		@(posedge sys_clk);
		fault_ev <= '0;
		done_ev <= '0;
		step(2);
	endtask

	task automatic tally_and_finish;
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		step(4);
		rst_b <= 1'b1;
		exp_fault = `ASFR_FAULT_RESET;
		flt_chk;
		rd_chk(`ASFR_POS_OFFSET, pos_word(12'h000, 12'h000, 1'b0, 2'b00));
		i_host.read_reg(8'h26, 0, data, vld, unm);
		chk(16'h0000, data);
		chk(16'h0001, {15'h0000, unm});
		i_host.pulse(1'b1, 1'b0);
		exp_fault = `ASFR_FLT_ZERO;
		flt_chk;
		// each event source for bits 1 to 10 latches its own bit and stays after the event
		for (i = 1; i < 11; i++)
		begin
			fire(12'h001 << i, 3'b000);
			exp_fault[i] = 1'b1;
			flt_chk;
		end
		// an event not yet read survives the clear
		fire(12'h001, 3'b000);
		i_host.pulse(1'b1, 1'b0);
		exp_fault = 12'h001;
		flt_chk;
		i_host.pulse(1'b1, 1'b0);
		// supply undervoltage held through a clear, then masked from the live flag
		fault_ev.supply_uv <= 1'b1;
		exp_fault = 12'h008;
		step(3);
		rd_chk(`ASFR_POS_OFFSET, pos_word(12'h000, 12'h000, 1'b0, 2'b10));
		flt_chk;
		i_host.pulse(1'b1, 1'b0);
		flag_mask_bits <= 12'h008;
		step(3);
		flt_chk;
		rd_chk(`ASFR_POS_OFFSET, pos_word(12'h000, 12'h008, 1'b0, 2'b10));
		step(1);
		fault_ev <= '0;
		flag_mask_bits <= 12'h800;
		caution_any <= 1'b1;
		i_host.pulse(1'b1, 1'b0);
		exp_fault = 12'h000;
		step(3);
		flt_chk;
		rd_chk(`ASFR_POS_OFFSET, pos_word(12'h000, 12'h800, 1'b1, 2'b00));
		step(1);
		flag_mask_bits <= 12'h000;
		step(3);
		exp_fault = 12'h800;
		flt_chk;
		step(1);
		caution_any <= 1'b0;
		i_host.pulse(1'b1, 1'b0);
		// random angle, mask and condition inputs with one latched fault
		fire(12'h080, 3'b000);
		exp_fault = 12'h080;
		flt_chk;
		for (i = 0; i < 24; i++)
		begin
			step(1);
			angle_code <= 12'($random(seed));
			flag_mask_bits <= 12'($random(seed)) & 12'hFF3;
			cond_in <= 7'($random(seed));
			step(3);
			exp_w = pos_word(angle_code, flag_mask_bits, 1'b0, 2'b00);
			rd_chk(`ASFR_POS_OFFSET, exp_w);
			chk({15'h0000, exp_w[14]}, {15'h0000, summary_fault_flag_ff});
			rd_chk(`ASFR_COND_OFFSET, cond_word(cond_in, 1'b0, 1'b0, 1'b0));
		end
		// done flags: boot, special trigger and completion, host wipe
		step(1);
		cond_in <= 7'h01;
		fire(12'h000, 3'b001);
		rd_chk(`ASFR_COND_OFFSET, cond_word(cond_in, 1'b0, 1'b1, 1'b1));
		fire(12'h000, 3'b010);
		rd_chk(`ASFR_COND_OFFSET, cond_word(cond_in, 1'b1, 1'b1, 1'b1));
		fire(12'h000, 3'b100);
		rd_chk(`ASFR_COND_OFFSET, cond_word(cond_in, 1'b0, 1'b1, 1'b1));
		fire(12'h000, 3'b010);
		i_host.pulse(1'b0, 1'b1);
		rd_chk(`ASFR_COND_OFFSET, cond_word(cond_in, 1'b0, 1'b0, 1'b1));
		step(1);
		cond_in <= 7'h03;
		step(2);
		rd_chk(`ASFR_COND_OFFSET, cond_word(cond_in, 1'b0, 1'b0, 1'b1));
		// completions in the same cycle as clear-done: the sets must win
		fork
			i_host.pulse(1'b0, 1'b1);
			fire(12'h000, 3'b011);
		join
		rd_chk(`ASFR_COND_OFFSET, cond_word(cond_in, 1'b1, 1'b1, 1'b1));
		tally_and_finish;
	end

	// hang guard
	initial
	begin
		#200000;
		num_errors++;
		tally_and_finish;
	end
endmodule // asfr_regs_tb_top
